// >>> src/key_fields_pkg.sv
package key_fields_pkg;

  // Register byte offsets.
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] SKIP_OFFSET   = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] COUNT_OFFSET  = 4'hc;

  // Control register fields.
  localparam int CTRL_DSCP_SEL_BIT = 0;
  localparam int CTRL_SKIP_ALL_BIT = 1;
  localparam int CTRL_KEY_TYPE_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] SKIP_RESET = 16'h0000;

  // Status register fields.
  localparam int STATUS_POS_LSB   = 0;
  localparam int STATUS_VAL_LSB   = 4;
  localparam int STATUS_VALID_BIT = 8;

  // Wide key variants.
  typedef enum logic [1:0] {
    KEY_MAC_LABEL   = 2'h0,
    KEY_TRIPLE      = 2'h1,
    KEY_IPV4_TUPLE  = 2'h2,
    KEY_CUSTOM      = 2'h3
  } wide_key_type_t;

  // Reserved label handling.
  localparam logic [19:0] RSV_LABEL_MAX    = 20'h0000f;
  localparam logic [2:0]  RSV_POS_LAST     = 3'h3;
  localparam logic [2:0]  RSV_POS_NONE     = 3'h5;
  localparam int          STACK_DEPTH      = 4;
  localparam logic [7:0]  TTL_EXPIRY_LIMIT = 8'h01;

  // IPv4 header figures.
  localparam logic [3:0] IPV4_MIN_IHL = 4'h5;

  // Ethernet layer and custom field sizes in bytes.
  localparam int ETH_MAC_PAIR_BYTES  = 12;
  localparam int ETH_TYPE_BYTES      = 2;
  localparam int ETH_VLAN_TAG_BYTES  = 4;
  localparam int CUSTOM_BYTES        = 15;

endpackage : key_fields_pkg

// >>> src/key_fields.sv
// Functional notes
// - Key carries third label entry: 20-bit label, 3-bit class, bottom flag.
// - Third entry expiry flag set when its time-to-live is at most one.
// - Four-bit reserved label value, meaningful only when position code is not 5 (none).
// - Position code: 0-2 seen or skipped, 3 seen, 4 unused, 5 none.
// - Label positions count from stack top, position 0 first.
// - Skip reserved label only if its own or per-lookup skip enable set.
// - Control word is the 32 bits following the bottom-of-stack label.
// - Fragment flag: IPv4 with more-fragments set or nonzero offset.
// - Non-first-fragment flag: IPv4 with fragment offset above zero.
// - Options flag when IPv4 header length exceeds five words; options unparsed.
// - DSCP field is frame DSCP unless classified DSCP selected.
// - Destination field: IPv4 address, or IPv6 address bits 31:0.
// - LLC frames: source field is control byte then payload bytes 0-2.
// - SNAP frames: source field is protocol id bytes 2-0 then payload byte 0.
// - Source field: IPv4 source, or IPv6 source bits 31:0.
// - Other frames: source field is payload bytes 0-3.
// - Protocol field: IPv4 protocol or IPv6 next header.
// - Range mask mirrors range checker results, DSCP checker uses remapped value.
// - IP payload word always taken 20 bytes after IPv4 header start.
// - Custom field: 15 payload bytes from the current frame pointer.
// - Ethernet frames: custom bytes start after MACs, 0-3 tags, EtherType.
// - Two-bit key type selects among the four wide-key variants.
`timescale 1ns/1ps
module key_fields #(
  parameter int FRAME_BYTES = 64,
  parameter int PTR_W       = 6
) (
  // Clock, reset and enable.
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Wishbone slave.
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [3:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Parsed frame from the parser.
  input  wire logic                     frame_valid_i,
  input  wire logic [159:0]             mpls_words_i,
  input  wire logic [2:0]               mpls_count_i,
  input  wire logic                     length_type_flag_i,
  input  wire logic                     snap_or_ip_flag_i,
  input  wire logic                     ipv4_frame_flag_i,
  input  wire logic                     ethernet_frame_i,
  input  wire logic [1:0]               vlan_count_i,
  input  wire logic                     more_fragments_i,
  input  wire logic [12:0]              fragment_offset_i,
  input  wire logic [3:0]               header_length_i,
  input  wire logic [5:0]               frame_dscp_i,
  input  wire logic [5:0]               classified_dscp_i,
  input  wire logic [31:0]              ip_destination_i,
  input  wire logic [31:0]              ip_source_i,
  input  wire logic [7:0]               ip_protocol_i,
  input  wire logic [7:0]               llc_control_i,
  input  wire logic [23:0]              snap_protocol_id_i,
  input  wire logic [31:0]              payload_head_i,
  input  wire logic [31:0]              ip_payload_at_20_i,
  input  wire logic [7:0]               range_results_i,
  input  wire logic [PTR_W-1:0]         frame_pointer_i,
  input  wire logic [FRAME_BYTES*8-1:0] frame_data_i,
  // Lookup key toward the classification lookup.
  output logic                          key_valid_o,
  output logic      [1:0]               wide_key_type_o,
  output logic      [19:0]              third_label_value_o,
  output logic      [2:0]               third_label_traffic_class_o,
  output logic                          third_label_bottom_flag_o,
  output logic                          third_label_expiry_flag_o,
  output logic      [3:0]               reserved_label_value_o,
  output logic      [2:0]               reserved_label_position_o,
  output logic      [31:0]              control_word_field_o,
  output logic                          ipv4_fragmented_flag_o,
  output logic                          ipv4_non_first_fragment_flag_o,
  output logic                          ipv4_has_options_flag_o,
  output logic      [5:0]               dscp_key_field_o,
  output logic      [31:0]              destination_ip_field_o,
  output logic      [31:0]              source_ip_overloaded_field_o,
  output logic      [7:0]               ip_protocol_field_o,
  output logic      [7:0]               range_check_mask_o,
  output logic      [31:0]              ip_payload_word_o,
  output logic      [119:0]             custom_payload_bytes_o
);

  logic [31:0] ctrl;
  logic [15:0] per_label_skip_enable;
  logic [31:0] key_count;
  logic        last_valid;
  logic        bus_req;
  logic        use_classified_dscp_select;
  logic        per_lookup_skip_enable;
  logic        bus_write;
  logic        take_frame;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // A write lands at the edge where the master sees ack, while its data is still held.
  assign bus_write  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  // A frame is only taken while the clock enable is high.
  assign take_frame = ce_i & frame_valid_i;
  assign use_classified_dscp_select = ctrl[key_fields_pkg::CTRL_DSCP_SEL_BIT];
  assign per_lookup_skip_enable     = ctrl[key_fields_pkg::CTRL_SKIP_ALL_BIT];

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Bus acknowledge, one cycle after the request is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
    end
  end

  // Control register write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= key_fields_pkg::CTRL_RESET;
    end else if (ce_i && bus_write && wb_adr_i == key_fields_pkg::CTRL_OFFSET) begin
      ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
    end
  end

  // Per-label skip enables, one bit for each reserved label value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_label_skip_enable <= key_fields_pkg::SKIP_RESET;
    end else if (ce_i && bus_write && wb_adr_i == key_fields_pkg::SKIP_OFFSET) begin
      per_label_skip_enable <= 16'(merge({16'h0000, per_label_skip_enable}, wb_dat_i, wb_sel_i));
    end
  end

  // Read data; unmapped offsets read as zero.
  // Data is cleared outside the ack cycle, so no stale word reaches the bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          key_fields_pkg::CTRL_OFFSET: begin
            wb_dat_o <= ctrl;
          end
          key_fields_pkg::SKIP_OFFSET: begin
            wb_dat_o <= {16'h0000, per_label_skip_enable};
          end
          key_fields_pkg::STATUS_OFFSET: begin
            wb_dat_o[key_fields_pkg::STATUS_POS_LSB +: 3] <= reserved_label_position_o;
            wb_dat_o[key_fields_pkg::STATUS_VAL_LSB +: 4] <= reserved_label_value_o;
            wb_dat_o[key_fields_pkg::STATUS_VALID_BIT]    <= last_valid;
          end
          key_fields_pkg::COUNT_OFFSET: begin
            wb_dat_o <= key_count;
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Reserved label scan from the top of the stack.
  // Words beyond the entries present are ignored, so stale stack data never counts.
  logic [2:0]  next_rsv_pos;
  logic [3:0]  next_rsv_val;
  logic [31:0] next_cw;
  always_comb begin
    logic        stop;
    logic        cw_found;
    logic [31:0] entry;
    stop         = 1'b0;
    cw_found     = 1'b0;
    entry        = 32'h0000_0000;
    next_rsv_pos = key_fields_pkg::RSV_POS_NONE;
    next_rsv_val = 4'h0;
    next_cw      = 32'h0000_0000;
    for (int p = 0; p < key_fields_pkg::STACK_DEPTH; p++) begin
      entry = mpls_words_i[p*32 +: 32];
      if (!stop && 3'(p) < mpls_count_i && entry[31:12] <= key_fields_pkg::RSV_LABEL_MAX) begin
        next_rsv_pos = 3'(p);
        next_rsv_val = entry[15:12];
        if (!(per_label_skip_enable[entry[15:12]] || per_lookup_skip_enable) ||
            3'(p) == key_fields_pkg::RSV_POS_LAST) begin
          stop = 1'b1;
        end
      end else if (3'(p) < mpls_count_i) begin
        stop = 1'b1;
      end
      if (!cw_found && 3'(p) < mpls_count_i && entry[8]) begin
        cw_found = 1'b1;
        next_cw  = mpls_words_i[(p+1)*32 +: 32];
      end
    end
  end

  // Custom bytes from the frame pointer.
  // Bytes past the end of the captured frame read as zero rather than wrapping.
  logic [119:0] next_custom;
  always_comb begin
    int start;
    int idx;
    start       = 0;
    idx         = 0;
    next_custom = 120'h0;
    if (ethernet_frame_i) begin
      start = key_fields_pkg::ETH_MAC_PAIR_BYTES + key_fields_pkg::ETH_TYPE_BYTES +
              int'(vlan_count_i) * key_fields_pkg::ETH_VLAN_TAG_BYTES;
    end
    start = start + int'(frame_pointer_i);
    for (int k = 0; k < key_fields_pkg::CUSTOM_BYTES; k++) begin
      idx = start + k;
      if (idx < FRAME_BYTES) begin
        next_custom[(14-k)*8 +: 8] = frame_data_i[idx*8 +: 8];
      end
    end
  end

  // Overloaded source field.
  logic [31:0] next_source;
  always_comb begin
    next_source = payload_head_i;
    if (!length_type_flag_i && !snap_or_ip_flag_i) begin
      next_source = {llc_control_i, payload_head_i[31:8]};
    end else if (!length_type_flag_i) begin
      next_source = {snap_protocol_id_i, payload_head_i[31:24]};
    end else if (snap_or_ip_flag_i) begin
      next_source = ip_source_i;
    end else begin
      next_source = payload_head_i;
    end
  end

  // Key valid strobe, one cycle for each frame taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_valid_o <= 1'b0;
    end else if (ce_i) begin
      key_valid_o <= frame_valid_i;
    end
  end

  // Statistics for the status and count registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_valid <= 1'b0;
      key_count  <= 32'h0000_0000;
    end else if (take_frame) begin
      last_valid <= 1'b1;
      key_count  <= key_count + 32'h0000_0001;
    end
  end

  // Wide key type, chosen by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wide_key_type_o <= 2'h0;
    end else if (take_frame) begin
      wide_key_type_o <= ctrl[key_fields_pkg::CTRL_KEY_TYPE_LSB +: 2];
    end
  end

  // Third stack entry, taken raw so that skipped labels never shift it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      third_label_value_o         <= 20'h00000;
      third_label_traffic_class_o <= 3'h0;
      third_label_bottom_flag_o   <= 1'b0;
      third_label_expiry_flag_o   <= 1'b0;
    end else if (take_frame) begin
      third_label_value_o         <= mpls_words_i[64+12 +: 20];
      third_label_traffic_class_o <= mpls_words_i[64+9 +: 3];
      third_label_bottom_flag_o   <= mpls_words_i[64+8];
      third_label_expiry_flag_o   <= mpls_words_i[64 +: 8] <= key_fields_pkg::TTL_EXPIRY_LIMIT;
    end
  end

  // Reserved label result and control word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reserved_label_value_o    <= 4'h0;
      reserved_label_position_o <= key_fields_pkg::RSV_POS_NONE;
      control_word_field_o      <= 32'h0000_0000;
    end else if (take_frame) begin
      reserved_label_value_o    <= (next_rsv_pos != key_fields_pkg::RSV_POS_NONE) ?
                                   next_rsv_val : 4'h0;
      reserved_label_position_o <= next_rsv_pos;
      control_word_field_o      <= next_cw;
    end
  end

  // IPv4 header flags; other frames leave them clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ipv4_fragmented_flag_o         <= 1'b0;
      ipv4_non_first_fragment_flag_o <= 1'b0;
      ipv4_has_options_flag_o        <= 1'b0;
    end else if (take_frame) begin
      ipv4_fragmented_flag_o         <= ipv4_frame_flag_i &&
                                        (more_fragments_i || fragment_offset_i != 13'h0000);
      ipv4_non_first_fragment_flag_o <= ipv4_frame_flag_i && fragment_offset_i != 13'h0000;
      ipv4_has_options_flag_o        <= ipv4_frame_flag_i &&
                                        header_length_i > key_fields_pkg::IPV4_MIN_IHL;
    end
  end

  // DSCP of the key.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dscp_key_field_o <= 6'h00;
    end else if (take_frame) begin
      dscp_key_field_o <= use_classified_dscp_select ?
                          classified_dscp_i : frame_dscp_i;
    end
  end

  // Addresses and protocol.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      destination_ip_field_o       <= 32'h0000_0000;
      source_ip_overloaded_field_o <= 32'h0000_0000;
      ip_protocol_field_o          <= 8'h00;
    end else if (take_frame) begin
      destination_ip_field_o       <= ip_destination_i;
      source_ip_overloaded_field_o <= next_source;
      ip_protocol_field_o          <= ip_protocol_i;
    end
  end

  // Range mask and payload words.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      range_check_mask_o     <= 8'h00;
      ip_payload_word_o      <= 32'h0000_0000;
      custom_payload_bytes_o <= 120'h0;
    end else if (take_frame) begin
      range_check_mask_o     <= range_results_i;
      ip_payload_word_o      <= ip_payload_at_20_i;
      custom_payload_bytes_o <= next_custom;
    end
  end

endmodule : key_fields

// >>> bench/key_fields_props.sv
`timescale 1ns/1ps
module key_fields_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        frame_valid_i,
  input wire logic        key_valid_o,
  input wire logic        ipv4_frame_flag_i,
  input wire logic        more_fragments_i,
  input wire logic [12:0] fragment_offset_i,
  input wire logic [3:0]  header_length_i,
  input wire logic        ipv4_fragmented_flag_o,
  input wire logic        ipv4_non_first_fragment_flag_o,
  input wire logic        ipv4_has_options_flag_o,
  input wire logic [2:0]  reserved_label_position_o,
  input wire logic [3:0]  reserved_label_value_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_frame;
    ce_i && frame_valid_i;
  endsequence
  a_bus_ack_due: assert property (s_req |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_key_after_frame: assert property (s_frame |=> key_valid_o)
    else $error("key not built after frame");
  a_key_has_cause: assert property (key_valid_o |-> $past(frame_valid_i))
    else $error("key without frame");
  a_fragment_flag: assert property (s_frame |=> ipv4_fragmented_flag_o ==
    ($past(ipv4_frame_flag_i) &&
     ($past(more_fragments_i) || $past(fragment_offset_i) != 13'h0)))
    else $error("fragment flag wrong");
  a_non_first_flag: assert property (s_frame |=> ipv4_non_first_fragment_flag_o ==
    ($past(ipv4_frame_flag_i) && $past(fragment_offset_i) != 13'h0))
    else $error("non-first flag wrong");
  a_options_flag: assert property (s_frame |=> ipv4_has_options_flag_o ==
    ($past(ipv4_frame_flag_i) && $past(header_length_i) > 4'h5))
    else $error("options flag wrong");
  a_position_legal: assert property (reserved_label_position_o != 3'h4 &&
    reserved_label_position_o <= 3'h5)
    else $error("illegal position code");
  a_none_zero_value: assert property (reserved_label_position_o == 3'h5 |->
    reserved_label_value_o == 4'h0)
    else $error("value set without reserved label");
endmodule : key_fields_props

bind key_fields key_fields_props key_fields_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .frame_valid_i(frame_valid_i), .key_valid_o(key_valid_o),
  .ipv4_frame_flag_i(ipv4_frame_flag_i), .more_fragments_i(more_fragments_i),
  .fragment_offset_i(fragment_offset_i), .header_length_i(header_length_i),
  .ipv4_fragmented_flag_o(ipv4_fragmented_flag_o),
  .ipv4_non_first_fragment_flag_o(ipv4_non_first_fragment_flag_o),
  .ipv4_has_options_flag_o(ipv4_has_options_flag_o),
  .reserved_label_position_o(reserved_label_position_o),
  .reserved_label_value_o(reserved_label_value_o));

// >>> bench/parser_model.sv
`timescale 1ns/1ps
module parser_model (
  // Clock.
  input wire logic clk_i
);
  logic         fv, ltf, sif, v4, eth, mf;
  logic [1:0]   vc;
  logic [2:0]   mc;
  logic [3:0]   hl;
  logic [5:0]   fd, cd, fp;
  logic [7:0]   llc, ipp, rr;
  logic [12:0]  fo;
  logic [23:0]  pid;
  logic [31:0]  dip, sip, ph, p20;
  logic [159:0] mw;
  logic [511:0] fdat;
  initial {fv, ltf, sif, v4, eth, mf, vc, mc, hl, fd, cd, fp, llc, fo, pid, dip, sip, ph, mw,
           fdat, ipp, rr, p20} = '0;
  // Stack and frame bytes turn to their inverse after the sampling edge, so stale data
  // can never pass for the fields of the frame just sent.
  task automatic send();
    fv <= 1'b1;
    @(posedge clk_i);
    fv <= 1'b0;
    mw <= ~mw;
    fdat <= ~fdat;
  endtask : send
endmodule : parser_model

// >>> bench/tb_key_fields.sv
`timescale 1ns/1ps
module tb_key_fields;
  logic         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
  logic [3:0]   adr = 4'h0, rv;
  logic [31:0]  dat = 32'h0, q, rdo, cw, dipo, sipo, pay;
  logic         ack, kv, bf, ex, fr, nf, op;
  logic [1:0]   kt;
  logic [2:0]   tc, rp;
  logic [5:0]   ds;
  logic [7:0]   pro, rm;
  logic [19:0]  tl;
  logic [119:0] cu;
  int           num_errors = 0, n_compared = 0;
  parser_model pm (.clk_i(clk_i));
  key_fields key_fields_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .frame_valid_i(pm.fv), .mpls_words_i(pm.mw), .mpls_count_i(pm.mc),
    .length_type_flag_i(pm.ltf), .snap_or_ip_flag_i(pm.sif), .ipv4_frame_flag_i(pm.v4),
    .ethernet_frame_i(pm.eth), .vlan_count_i(pm.vc), .more_fragments_i(pm.mf),
    .fragment_offset_i(pm.fo), .header_length_i(pm.hl), .frame_dscp_i(pm.fd),
    .classified_dscp_i(pm.cd), .ip_destination_i(pm.dip), .ip_source_i(pm.sip),
    .ip_protocol_i(pm.ipp), .llc_control_i(pm.llc), .snap_protocol_id_i(pm.pid),
    .payload_head_i(pm.ph), .ip_payload_at_20_i(pm.p20), .range_results_i(pm.rr),
    .frame_pointer_i(pm.fp), .frame_data_i(pm.fdat), .key_valid_o(kv),
    .wide_key_type_o(kt), .third_label_value_o(tl), .third_label_traffic_class_o(tc),
    .third_label_bottom_flag_o(bf), .third_label_expiry_flag_o(ex),
    .reserved_label_value_o(rv), .reserved_label_position_o(rp), .control_word_field_o(cw),
    .ipv4_fragmented_flag_o(fr), .ipv4_non_first_fragment_flag_o(nf),
    .ipv4_has_options_flag_o(op), .dscp_key_field_o(ds), .destination_ip_field_o(dipo),
    .source_ip_overloaded_field_o(sipo), .ip_protocol_field_o(pro),
    .range_check_mask_o(rm), .ip_payload_word_o(pay), .custom_payload_bytes_o(cu));
  always #50 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic go();
    pm.send();
    @(negedge clk_i);
    chk("key_valid", 1, kv);
    @(posedge clk_i);
  endtask : go
  task automatic t_regs();
    bus(4'h0, 1'b0, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(4'h2, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int k = 0; k < 4; k++) begin
      bus(4'h0, 1'b1, 32'(k * 16));
      go();
      chk("key_type", k, kt);
    end
    bus(4'h0, 1'b0, 32'h0);
    chk("ctrl", 32'h30, q);
  endtask : t_regs
  task automatic t_mpls();
    logic [7:0] c[5] = '{8'h0, 8'h2, 8'h0, 8'h0, 8'h0};
    logic [7:0] s[5] = '{8'h0, 8'h0, 8'h8, 8'h80, 8'h0};
    logic [2:0] p[5] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h5};
    logic [3:0] v[5] = '{4'h3, 4'h7, 4'h7, 4'h3, 4'h0};
    for (int i = 0; i < 5; i++) begin
      bus(4'h0, 1'b1, {24'h0, c[i]});
      bus(4'h4, 1'b1, {24'h0, s[i]});
      pm.mc <= 3'h4;
      pm.mw <= {32'hc0de0001, 32'h22222040, 24'habcdeb, (i == 4 ? 8'h02 : 8'h01),
                32'h00007000, (i == 4 ? 20'h00010 : 20'h00003), 12'h0};
      go();
      chk("position", p[i], rp);
      chk("rsv_value", v[i], rv);
      chk("third", 24'habcdeb, {tl, tc, bf});
      chk("expiry", i != 4, ex);
      chk("ctl_word", 32'h22222040, cw);
    end
    bus(4'h8, 1'b0, 32'h0);
    chk("status", 32'h105, q);
    bus(4'hc, 1'b0, 32'h0);
    chk("key_count", 32'h9, q);
  endtask : t_mpls
  task automatic t_dscp();
    bus(4'h0, 1'b1, 32'h0);
    pm.fd <= 6'h2a;
    pm.cd <= 6'h15;
    go();
    chk("dscp", 6'h2a, ds);
    bus(4'h0, 1'b1, 32'h1);
    go();
    chk("dscp", 6'h15, ds);
  endtask : t_dscp
  task automatic t_hold();
    pm.cd <= 6'h2c;
    ce <= 1'b0;
    pm.send();
    @(negedge clk_i);
    chk("key_valid", 0, kv);
    chk("dscp", 6'h15, ds);
    @(posedge clk_i);
    ce <= 1'b1;
  endtask : t_hold
  task automatic ipf(input logic m, input logic [12:0] o, input logic [3:0] h, input logic v);
    pm.mf <= m;
    pm.fo <= o;
    pm.hl <= h;
    pm.v4 <= v;
    go();
    chk("fragment", v && (m || o != 13'h0), fr);
    chk("non_first", v && o != 13'h0, nf);
    chk("options", v && h > 4'h5, op);
  endtask : ipf
  task automatic srcf(input logic l, input logic s, input logic v, input logic [31:0] e);
    pm.ltf <= l;
    pm.sif <= s;
    pm.v4 <= v;
    pm.dip <= {e[15:0], e[31:16]};
    pm.ipp <= e[7:0];
    pm.rr <= e[15:8];
    pm.p20 <= e ^ 32'hffff_ffff;
    go();
    chk("source", e, sipo);
    chk("dest", {e[15:0], e[31:16]}, dipo);
    chk("proto", e[7:0], pro);
    chk("range", e[15:8], rm);
    chk("payload", e ^ 32'hffff_ffff, pay);
  endtask : srcf
  task automatic t_cust(input logic e, input logic [1:0] n, input logic [5:0] f);
    int b;
    b = f + (e ? 14 + 4 * n : 0);
    pm.eth <= e;
    pm.vc <= n;
    pm.fp <= f;
    for (int i = 0; i < 64; i++) pm.fdat[i*8+:8] <= 8'(i);
    go();
    for (int k = 0; k < 15; k++) chk("custom", 8'(b + k), cu[119-8*k-:8]);
  endtask : t_cust
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reset_pos", 3'h5, rp);
    t_regs();
    t_mpls();
    t_dscp();
    t_hold();
    ipf(1'b1, 13'h0, 4'h5, 1'b1);
    ipf(1'b0, 13'h1, 4'h5, 1'b1);
    ipf(1'b0, 13'h0, 4'h6, 1'b1);
    ipf(1'b1, 13'h1fff, 4'hf, 1'b0);
    pm.llc <= 8'h11;
    pm.pid <= 24'h223344;
    pm.ph <= 32'h55667788;
    pm.sip <= 32'h99aabbcc;
    pm.dip <= 32'hd1d2d3d4;
    srcf(1'b0, 1'b0, 1'b0, 32'h11556677);
    srcf(1'b0, 1'b1, 1'b0, 32'h22334455);
    srcf(1'b1, 1'b1, 1'b1, 32'h99aabbcc);
    srcf(1'b1, 1'b1, 1'b0, 32'h99aabbcc);
    srcf(1'b1, 1'b0, 1'b0, 32'h55667788);
    t_cust(1'b1, 2'h3, 6'h6);
    t_cust(1'b0, 2'h0, 6'h9);
    report_and_stop();
  end
endmodule : tb_key_fields
